// >>> design/dcf_fifo_ctrl.sv
// Dual-clock FIFO control: memory, pointers, flags, clears, replay, offsets, APB access.
// Assumes write and read clocks arrive as pins slower than ref_clk and are edge-detected.
`default_nettype none
`include "dcf_params.svh"

module dcf_fifo_ctrl (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic full_clear_n,
   input wire logic soft_clear_n,
   input wire logic write_clk,
   input wire logic read_clk,
   input wire logic write_enable_n,
   input wire logic read_enable_n,
   input wire logic replay_n,
   input wire logic fall_through_select,
   input wire logic offset_access_n,
   input wire logic serial_enable_n,
   input wire logic [8:0] data_in,
   output logic [8:0] data_out,
   output logic empty_n,
   output logic full_n,
   output logic output_ready_n,
   output logic input_ready_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   output logic half_full_n
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int PIN_W = 19;
   logic [PIN_W-1:0] pin_s1;
   logic [PIN_W-1:0] pin_s2;
   logic wclk_d;
   logic rclk_d;
   logic mrs_s;
   logic prs_s;
   logic wclk_s;
   logic rclk_s;
   logic wen_s;
   logic ren_s;
   logic rt_s;
   logic fts_s;
   logic ld_s;
   logic sen_s;
   logic [8:0] din_s;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pin_s1 <= {10'h3ff, 9'h000};
         pin_s2 <= {10'h3ff, 9'h000};
      end
      else
      begin
         pin_s1 <= {full_clear_n, soft_clear_n, write_clk, read_clk, write_enable_n, read_enable_n,
                    replay_n, fall_through_select, offset_access_n, serial_enable_n, data_in};
         pin_s2 <= pin_s1;
      end
   end

   assign {mrs_s, prs_s, wclk_s, rclk_s, wen_s, ren_s, rt_s, fts_s, ld_s, sen_s, din_s} = pin_s2;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         wclk_d <= 1'b1;
         rclk_d <= 1'b1;
      end
      else
      begin
         wclk_d <= wclk_s;
         rclk_d <= rclk_s;
      end
   end

   logic wr_edge;
   logic rd_edge;
   logic clr_full;
   logic clr_any;
   assign wr_edge = wclk_s & ~wclk_d;
   assign rd_edge = rclk_s & ~rclk_d;
   assign clr_full = ~mrs_s;
   assign clr_any = ~mrs_s | ~prs_s;

   // ----------------------------------------
   // Mode, loading method and offsets
   // ----------------------------------------
   logic mode_fall_through_select;
   logic par_load;
   dcf_pkg::dcf_off_t empty_off;
   dcf_pkg::dcf_off_t full_off;
   logic apb_wr;
   logic apb_rd_setup;
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd_setup = psel & ~penable;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         mode_fall_through_select <= 1'b0;
         par_load <= 1'b1;
         empty_off <= `DCF_OFF_PAR;
         full_off <= `DCF_OFF_PAR;
      end
      else if (clr_full)
      begin
         mode_fall_through_select <= fts_s;
         par_load <= ~ld_s;
         empty_off <= ld_s ? `DCF_OFF_SER : `DCF_OFF_PAR;
         full_off <= ld_s ? `DCF_OFF_SER : `DCF_OFF_PAR;
      end
      else if (wr_edge && !ld_s && !sen_s && !par_load)
      begin
         {full_off, empty_off} <= {fts_s, full_off, empty_off[13:1]};
      end
      else if (apb_wr && paddr == `DCF_REG_OFFSET && par_load)
      begin
         empty_off <= pwdata[`DCF_OFF_EMPTY_LSB +: `DCF_ADDR_W];
         full_off <= pwdata[`DCF_OFF_FULL_LSB +: `DCF_ADDR_W];
      end
   end

   // ----------------------------------------
   // Memory and write side
   // ----------------------------------------
   dcf_pkg::dcf_word_t mem [`DCF_DEPTH];
   dcf_pkg::dcf_ptr_t wptr;
   dcf_pkg::dcf_ptr_t cons_ptr;
   dcf_pkg::dcf_ptr_t wsync1;
   dcf_pkg::dcf_ptr_t wsync2;
   dcf_pkg::dcf_ptr_t rd_view;
   dcf_pkg::dcf_ptr_t level_w;
   dcf_pkg::dcf_ptr_t cap;
   dcf_pkg::dcf_ptr_t half;
   logic full;
   logic wr_fire;

   assign cap = mode_fall_through_select ? `DCF_CAP_FALL_THROUGH_SELECT : `DCF_CAP_STD;
   assign half = mode_fall_through_select ? `DCF_HALF_FALL_THROUGH_SELECT : `DCF_HALF_STD;
   assign rd_view = dcf_pkg::dcf_gray2bin(wsync2);
   assign level_w = wptr - rd_view;
   assign full = (level_w >= cap);
   assign wr_fire = wr_edge & ~wen_s & ~full & ~clr_any;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         wptr <= '0;
      end
      else if (wr_fire)
      begin
         wptr <= wptr + 15'h0001;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (wr_fire)
      begin
         mem[wptr[`DCF_ADDR_W-1:0]] <= din_s;
      end
   end

   // Consumed-word pointer crosses on write edges, two stages
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         wsync1 <= '0;
         wsync2 <= '0;
      end
      else if (wr_edge)
      begin
         wsync1 <= dcf_pkg::dcf_bin2gray(cons_ptr);
         wsync2 <= wsync1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         almost_full_n <= 1'b1;
      end
      else if (wr_edge)
      begin
         almost_full_n <= ~(level_w >= cap - {1'b0, full_off});
      end
   end

   // ----------------------------------------
   // Read side
   // ----------------------------------------
   dcf_pkg::dcf_ptr_t rptr;
   dcf_pkg::dcf_ptr_t rsync1;
   dcf_pkg::dcf_ptr_t rsync2;
   dcf_pkg::dcf_ptr_t wr_view;
   dcf_pkg::dcf_ptr_t avail;
   dcf_pkg::dcf_ptr_t level_r;
   dcf_pkg::dcf_rt_state_t rt_state;
   dcf_pkg::dcf_rt_state_t next_rt_state;
   logic or_valid;
   logic busy;
   logic has_word;
   logic rd_fire;
   logic or_drop;

   assign wr_view = dcf_pkg::dcf_gray2bin(rsync2);
   assign avail = wr_view - rptr;
   assign has_word = (avail != '0);
   assign cons_ptr = rptr - {14'h0000, or_valid};
   assign level_r = wr_view - cons_ptr;
   assign busy = (rt_state == dcf_pkg::rt_setup);
   assign rd_fire = rd_edge & ~busy & ~clr_any & has_word &
                    (mode_fall_through_select ? (~or_valid | ~ren_s) : ~ren_s);
   assign or_drop = rd_edge & ~busy & ~clr_any & mode_fall_through_select & or_valid & ~ren_s & ~has_word;

   // Write pointer crosses on read edges, two stages
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         rsync1 <= '0;
         rsync2 <= '0;
      end
      else if (rd_edge)
      begin
         rsync1 <= dcf_pkg::dcf_bin2gray(wptr);
         rsync2 <= rsync1;
      end
   end

   always_comb
   begin
      next_rt_state = rt_state;
      case (rt_state)
         dcf_pkg::rt_idle:
         begin
            if (rd_edge && !rt_s)
            begin
               next_rt_state = dcf_pkg::rt_setup;
            end
         end
         dcf_pkg::rt_setup:
         begin
            if (rd_edge)
            begin
               next_rt_state = dcf_pkg::rt_idle;
            end
         end
         default:
         begin
            next_rt_state = dcf_pkg::rt_idle;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         rt_state <= dcf_pkg::rt_idle;
      end
      else
      begin
         rt_state <= next_rt_state;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         rptr <= '0;
         or_valid <= 1'b0;
      end
      else if (rd_edge && !busy && !rt_s)
      begin
         rptr <= '0;
         or_valid <= 1'b0;
      end
      else if (rd_fire)
      begin
         rptr <= rptr + 15'h0001;
         or_valid <= mode_fall_through_select;
      end
      else if (or_drop)
      begin
         or_valid <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         data_out <= '0;
      end
      else if (rd_fire)
      begin
         data_out <= mem[rptr[`DCF_ADDR_W-1:0]];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         almost_empty_n <= 1'b0;
      end
      else if (rd_edge)
      begin
         almost_empty_n <= ~(level_r <= {1'b0, empty_off});
      end
   end

   // Half flag: write edge only lowers it, read edge only raises it
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || clr_any)
      begin
         half_full_n <= 1'b1;
      end
      else if (wr_edge && level_w > half)
      begin
         half_full_n <= 1'b0;
      end
      else if (rd_edge && level_r <= half)
      begin
         half_full_n <= 1'b1;
      end
   end

   // ----------------------------------------
   // Mode-dependent flag pins
   // ----------------------------------------
   assign empty_n = mode_fall_through_select ? 1'b1 : ~(busy | ~has_word);
   assign full_n = mode_fall_through_select ? 1'b1 : ~full;
   assign output_ready_n = mode_fall_through_select ? ~or_valid : 1'b1;
   assign input_ready_n = mode_fall_through_select ? full : 1'b1;

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   logic [31:0] next_prdata;
   logic mapped;
   assign mapped = (paddr == `DCF_REG_STATUS) || (paddr == `DCF_REG_OFFSET) || (paddr == `DCF_REG_LEVEL);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_comb
   begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         `DCF_REG_STATUS:
         begin
            next_prdata[`DCF_STS_MODE] = mode_fall_through_select;
            next_prdata[`DCF_STS_PAR] = par_load;
            next_prdata[`DCF_STS_BUSY] = busy;
            next_prdata[`DCF_STS_EMPTY] = ~has_word;
            next_prdata[`DCF_STS_FULL] = full;
            next_prdata[`DCF_STS_HALF] = ~half_full_n;
            next_prdata[`DCF_STS_AE] = ~almost_empty_n;
            next_prdata[`DCF_STS_AF] = ~almost_full_n;
         end
         `DCF_REG_OFFSET:
         begin
            next_prdata[`DCF_OFF_EMPTY_LSB +: `DCF_ADDR_W] = empty_off;
            next_prdata[`DCF_OFF_FULL_LSB +: `DCF_ADDR_W] = full_off;
         end
         `DCF_REG_LEVEL:
         begin
            next_prdata[`DCF_PTR_W-1:0] = level_w;
         end
         default:
         begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (apb_rd_setup)
      begin
         prdata <= next_prdata;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_replay_start;
      rd_edge && !rt_s && !busy && !clr_any;
   endsequence

   sequence s_replay_setup;
      busy && rptr == '0 && !or_valid && (mode_fall_through_select || !empty_n);
   endsequence

   a_clear_ptrs: assert property (clr_any |=> wptr == '0 && rptr == '0 && !almost_empty_n && half_full_n)
      else $error("pointers or flags not cleared");
   a_clear_data: assert property (clr_any |=> data_out == '0)
      else $error("output data not cleared");
   a_mode_sample: assert property (clr_full |=> mode_fall_through_select == $past(fts_s))
      else $error("mode not sampled at full clear");
   a_par_defaults: assert property (clr_full && !ld_s
      |=> par_load && empty_off == `DCF_OFF_PAR && full_off == `DCF_OFF_PAR)
      else $error("parallel defaults wrong");
   a_ser_defaults: assert property (clr_full && ld_s
      |=> !par_load && empty_off == `DCF_OFF_SER && full_off == `DCF_OFF_SER)
      else $error("serial defaults wrong");
   a_ser_no_apb: assert property (!clr_full && !par_load && !wr_edge && apb_wr |=> $stable(empty_off))
      else $error("offset written in serial method");
   a_soft_keeps: assert property (!sys_rst && !clr_full && !prs_s && !wr_edge && !apb_wr
      |=> $stable(full_off) && $stable(mode_fall_through_select))
      else $error("soft clear changed settings");
   a_full_blocks: assert property (wr_edge && full && !clr_any |=> $stable(wptr))
      else $error("write taken while full");
   a_std_hold: assert property (!mode_fall_through_select && rd_edge && ren_s && rt_s && !clr_any
      |=> $stable(data_out) && $stable(rptr))
      else $error("standard read without enable");
   a_empty_ign: assert property (rd_edge && !has_word && !clr_any && rt_s |=> $stable(rptr))
      else $error("read taken while empty");
   a_replay_seq: assert property (s_replay_start |=> s_replay_setup)
      else $error("replay setup wrong");
   a_half_write: assert property (!clr_any && !rd_edge && !half_full_n |=> !half_full_n)
      else $error("half flag raised without read edge");
   a_wside_idle: assert property (!wr_edge && !clr_any ##1 !wr_edge && !clr_any
      |-> $stable(almost_full_n) && $stable(full))
      else $error("write-side flag moved without write edge");

endmodule : dcf_fifo_ctrl

`default_nettype wire

// >>> design/dcf_params.svh
// Constants of the dual-clock FIFO control block: sizes, offsets, fields, defaults.
// Assumes inclusion by bare name from files that need the register map or the sizes.
//
// Overview of operation
// - Full clear resets both pointers, almost-empty low, almost-full and half high.
// - Full clear samples mode pin: standard or fall-through, with matching flag levels.
// - Offset access low at full clear: offsets 127, parallel loading only.
// - Offset access high at full clear: offsets 1023, serial loading only.
// - Offsets can always be read back in parallel.
// - Full clear zeroes the output data register.
// - Soft clear resets pointers and flags like full clear but keeps the mode.
// - Soft clear keeps offsets and loading method, zeroes output data.
// - Standard replay: empty low during setup, read pointer to start, then reads need enable.
// - Fall-through replay: ready high in setup, then first word shown without enable.
// - Standard mode delivers every word only on read edge with read enable low.
// - Fall-through shows first word after three read edges without enable.
// - After full clear mode pin shifts serial offset bits when serial method chosen.
// - Write edge with write enable low and not full stores word sequentially.
// - Write enable ignored while full, in both modes.
// - Standard full flag low when full, high two write edges after a read.
// - Fall-through input-ready high when full, low two write edges after a read.
// - Write-side flags change only on write edges; write edge only lowers half flag.
// - Read-side flags change only on read edges; read edge only raises half flag.
// - Capacity 16384 words standard, 16385 fall-through counting output register.
// - Read enable ignored while empty; output holds while read enable high, except fall-through loading a word into an empty output register.
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

`define DCF_ADDR_W 14
`define DCF_PTR_W 15
`define DCF_DATA_W 9
`define DCF_DEPTH 16384
`define DCF_CAP_STD 15'h4000
`define DCF_CAP_FALL_THROUGH_SELECT 15'h4001
`define DCF_HALF_STD 15'h2000
`define DCF_HALF_FALL_THROUGH_SELECT 15'h2001
`define DCF_OFF_PAR 14'h007f
`define DCF_OFF_SER 14'h03ff

`define DCF_REG_STATUS 12'h000
`define DCF_REG_OFFSET 12'h004
`define DCF_REG_LEVEL 12'h008

`define DCF_STS_MODE 0
`define DCF_STS_PAR 1
`define DCF_STS_BUSY 2
`define DCF_STS_EMPTY 3
`define DCF_STS_FULL 4
`define DCF_STS_HALF 5
`define DCF_STS_AE 6
`define DCF_STS_AF 7
`define DCF_OFF_EMPTY_LSB 0
`define DCF_OFF_FULL_LSB 16

`endif

// >>> design/dcf_pkg.sv
// Types and pointer code conversions for the dual-clock FIFO control block.
// Assumes dcf_params.svh is on the include path.
`default_nettype none
`include "dcf_params.svh"

package dcf_pkg;
   typedef logic [`DCF_PTR_W-1:0] dcf_ptr_t;
   typedef logic [`DCF_ADDR_W-1:0] dcf_off_t;
   typedef logic [`DCF_DATA_W-1:0] dcf_word_t;
   typedef enum logic {rt_idle, rt_setup} dcf_rt_state_t;

   function automatic dcf_ptr_t dcf_bin2gray(input dcf_ptr_t b);
   begin
      return b ^ (b >> 1);
   end
   endfunction : dcf_bin2gray

   function automatic dcf_ptr_t dcf_gray2bin(input dcf_ptr_t g);
      dcf_ptr_t b;
   begin
      b = g;
      for (int i = `DCF_PTR_W - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   end
   endfunction : dcf_gray2bin
endpackage : dcf_pkg

`default_nettype wire

// >>> testbench/dcf_fifo_ctrl_test.sv
// Self-checking bench of the dual-clock FIFO control block: clears, modes, offsets, data, replay.
// Assumes dcf_host_model drives the link pins; the bench drives APB and the clear and mode pins.
`default_nettype none

module dcf_fifo_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk = 1'b0, sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr;
   logic full_clear_n = 1'b1, soft_clear_n = 1'b1, fall_through_select = 1'b0;
   logic offset_access_n = 1'b1, serial_enable_n = 1'b1;
   logic write_clk, read_clk, write_enable_n, read_enable_n, replay_n;
   logic [8:0] data_in, data_out;
   logic empty_n, full_n, output_ready_n, input_ready_n, almost_empty_n, almost_full_n, half_full_n;
   int errors = 0, total_checks = 0;
   logic [8:0] words [3] = '{9'h1a5, 9'h05a, 9'h1ff};

   dcf_fifo_ctrl i_dut (
      .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .full_clear_n, .soft_clear_n, .write_clk, .read_clk, .write_enable_n, .read_enable_n,
      .replay_n, .fall_through_select, .offset_access_n, .serial_enable_n, .data_in, .data_out,
      .empty_n, .full_n, .output_ready_n, .input_ready_n, .almost_empty_n, .almost_full_n,
      .half_full_n
   );

   dcf_host_model u_host (
      .ref_clk, .write_clk, .read_clk, .write_enable_n, .read_enable_n, .replay_n, .data_in
   );

   always #5 ref_clk = ~ref_clk;

   // ----------------------------------------
   // Reporting and compares
   // ----------------------------------------
   task automatic end_of_test();
   begin
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   end
   endtask : end_of_test

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
   begin
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask : chk_word

   task automatic chk_data(input logic [8:0] got, input logic [8:0] exp);
   begin
      chk_word({23'h0, got}, {23'h0, exp});
   end
   endtask : chk_data

   task automatic chk_flag(input logic got, input logic exp);
   begin
      chk_word({31'h0, got}, {31'h0, exp});
   end
   endtask : chk_flag

   // ----------------------------------------
   // APB master and clear pulses
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
   begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         errors++;
         end_of_test();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask : apb

   task automatic clear(input logic full, input logic fts, input logic oan);
   begin
      @(posedge ref_clk);
      fall_through_select <= fts;
      offset_access_n <= oan;
      full_clear_n <= ~full;
      soft_clear_n <= full;
      repeat (6) @(posedge ref_clk);
      full_clear_n <= 1'b1;
      soft_clear_n <= 1'b1;
      offset_access_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
   end
   endtask : clear

   task automatic chk_clear(input logic ft);
   begin
      chk_flag(almost_empty_n, 1'b0);
      chk_flag(almost_full_n, 1'b1);
      chk_flag(half_full_n, 1'b1);
      chk_flag(empty_n, ft);
      chk_flag(full_n, 1'b1);
      chk_flag(output_ready_n, 1'b1);
      chk_flag(input_ready_n, ~ft);
      chk_data(data_out, 9'h000);
   end
   endtask : chk_clear

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_start();
   begin
      clear(1'b1, 1'b0, 1'b0);
      chk_clear(1'b0);
      apb(1'b0, 12'h000, 32'h0);
      chk_word(rdat & 32'h3, 32'h2);
      apb(1'b0, 12'h004, 32'h0);
      chk_word(rdat, 32'h007f007f);
      apb(1'b0, 12'h00c, 32'h0);
      chk_flag(rerr, 1'b1);
      chk_word(rdat, 32'h0);
   end
   endtask : t_start

   task automatic t_std_rw();
   begin
      foreach (words[i])
      begin
         u_host.wr_cycle(1'b0, words[i]);
      end
      u_host.wr_cycle(1'b1, 9'h0aa);
      apb(1'b0, 12'h008, 32'h0);
      chk_word(rdat, 32'h3);
      repeat (3) u_host.rd_cycle(1'b1, 1'b1);
      chk_flag(empty_n, 1'b1);
      chk_data(data_out, 9'h000);
      foreach (words[i])
      begin
         u_host.rd_cycle(1'b0, 1'b1);
         chk_data(data_out, words[i]);
      end
      u_host.rd_cycle(1'b0, 1'b1);
      chk_data(data_out, 9'h1ff);
      chk_flag(empty_n, 1'b0);
   end
   endtask : t_std_rw

   task automatic t_std_replay();
   begin
      u_host.rd_cycle(1'b1, 1'b0);
      u_host.rd_cycle(1'b1, 1'b1);
      chk_flag(empty_n, 1'b1);
      u_host.rd_cycle(1'b1, 1'b1);
      chk_data(data_out, 9'h1ff);
      u_host.rd_cycle(1'b0, 1'b1);
      chk_data(data_out, 9'h1a5);
      u_host.rd_cycle(1'b1, 1'b0);
      chk_flag(empty_n, 1'b0);
      u_host.rd_cycle(1'b1, 1'b1);
      chk_flag(empty_n, 1'b1);
      u_host.rd_cycle(1'b0, 1'b1);
      chk_data(data_out, 9'h1a5);
   end
   endtask : t_std_replay

   task automatic t_soft();
   begin
      apb(1'b1, 12'h004, 32'h00200010);
      clear(1'b0, 1'b1, 1'b1);
      chk_clear(1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chk_word(rdat, 32'h00200010);
      apb(1'b0, 12'h000, 32'h0);
      chk_word(rdat & 32'h3, 32'h2);
   end
   endtask : t_soft

   task automatic t_ft();
      logic [27:0] sv;
   begin
      sv = {14'h0155, 14'h00aa};
      clear(1'b1, 1'b1, 1'b1);
      chk_clear(1'b1);
      apb(1'b0, 12'h000, 32'h0);
      chk_word(rdat & 32'h3, 32'h1);
      apb(1'b1, 12'h004, 32'h11111111);
      apb(1'b0, 12'h004, 32'h0);
      chk_word(rdat, 32'h03ff03ff);
      @(posedge ref_clk);
      offset_access_n <= 1'b0;
      serial_enable_n <= 1'b0;
      for (int i = 0; i < 28; i++)
      begin
         @(posedge ref_clk);
         fall_through_select <= sv[i];
         u_host.wr_cycle(1'b1, 9'h000);
      end
      offset_access_n <= 1'b1;
      serial_enable_n <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk_word(rdat, 32'h015500aa);
      u_host.wr_cycle(1'b0, 9'h133);
      u_host.wr_cycle(1'b0, 9'h0cc);
      repeat (2) u_host.rd_cycle(1'b1, 1'b1);
      chk_flag(output_ready_n, 1'b1);
      u_host.rd_cycle(1'b1, 1'b1);
      chk_flag(output_ready_n, 1'b0);
      chk_data(data_out, 9'h133);
      chk_flag(input_ready_n, 1'b0);
      u_host.rd_cycle(1'b1, 1'b1);
      chk_data(data_out, 9'h133);
      u_host.rd_cycle(1'b0, 1'b1);
      chk_data(data_out, 9'h0cc);
      u_host.rd_cycle(1'b1, 1'b0);
      chk_flag(output_ready_n, 1'b1);
      repeat (2) u_host.rd_cycle(1'b1, 1'b1);
      chk_flag(output_ready_n, 1'b0);
      chk_data(data_out, 9'h133);
      u_host.rd_cycle(1'b0, 1'b1);
      chk_data(data_out, 9'h0cc);
      u_host.rd_cycle(1'b0, 1'b1);
      chk_flag(output_ready_n, 1'b1);
      chk_data(data_out, 9'h0cc);
   end
   endtask : t_ft

   initial
   begin
      #900us;
      errors++;
      end_of_test();
   end

   initial
   begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_start();
      t_std_rw();
      t_std_replay();
      t_soft();
      t_ft();
      end_of_test();
   end
endmodule : dcf_fifo_ctrl_test

`default_nettype wire

// >>> testbench/dcf_host_model.sv
// Host-side model: write agent and read agent of the FIFO, with gated link clocks.
// Assumes ref_clk at 100 MHz; each link clock pulse is high for 62.5 ns, half a 125 ns period, still between transfers.
`default_nettype none

module dcf_host_model (
   input wire logic ref_clk,
   output logic write_clk,
   output logic read_clk,
   output logic write_enable_n,
   output logic read_enable_n,
   output logic replay_n,
   output logic [8:0] data_in
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      write_clk = 1'b0;
      read_clk = 1'b0;
      write_enable_n = 1'b1;
      read_enable_n = 1'b1;
      replay_n = 1'b1;
      data_in = 9'h000;
   end

   // ----------------------------------------
   // Write cycle, data line inverted once released
   // ----------------------------------------
   task automatic wr_cycle(input logic wen_n, input logic [8:0] d);
   begin
      @(posedge ref_clk);
      write_enable_n <= wen_n;
      data_in <= d;
      #63.7 write_clk = 1'b1;
      #62.5 write_clk = 1'b0;
      @(posedge ref_clk);
      write_enable_n <= 1'b1;
      data_in <= ~d;
   end
   endtask : wr_cycle

   // ----------------------------------------
   // Read cycle, optionally with replay request
   // ----------------------------------------
   task automatic rd_cycle(input logic ren_n, input logic rt_n);
   begin
      @(posedge ref_clk);
      read_enable_n <= rt_n ? ren_n : 1'b1;
      replay_n <= rt_n;
      #61.9 read_clk = 1'b1;
      #62.5 read_clk = 1'b0;
      @(posedge ref_clk);
      read_enable_n <= 1'b1;
      replay_n <= 1'b1;
   end
   endtask : rd_cycle
endmodule : dcf_host_model

`default_nettype wire
